/* lfosc_params.svh */
/*
 * Offsets, field positions, reset values and counts for the low-frequency
 * oscillator control block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef LFOSC_PARAMS_SVH
`define LFOSC_PARAMS_SVH

// ============================================================
// Control register
`define LFOSC_CTRL_ADDR      8'h86
`define LFOSC_ON_BIT         7
`define LFOSC_SETTLED_BIT    6
`define LFOSC_TRIM_HI        5
`define LFOSC_TRIM_LO        2
`define LFOSC_DIV_HI         1
`define LFOSC_DIV_LO         0
`define LFOSC_ON_RESET       1'h0
`define LFOSC_DIV_RESET      2'h0
`define LFOSC_TRIM_RESET     4'h0

// ============================================================
// Divider encodings
`define LFOSC_DIV_BY8        2'h0
`define LFOSC_DIV_BY4        2'h1
`define LFOSC_DIV_BY2        2'h2
`define LFOSC_DIV_BY1        2'h3

// ============================================================
// Settling: oscillator rising edges seen before the ready flag sets
`define LFOSC_SETTLE_EDGES   8

`endif

/* lfosc_pkg.sv */
/*
 * Types shared by the low-frequency oscillator control block.
 * Assumes lfosc_params.svh is available on the include path.
 */
package lfosc_pkg;
  `include "lfosc_params.svh"

  // ============================================================
  // Settling sequencer states, one-hot
  typedef enum logic [2:0] {
    SETTLE_IDLE = 3'h1,
    SETTLE_WAIT = 3'h2,
    SETTLE_DONE = 3'h4
  } settle_state_t;

  typedef logic [7:0] sfr_byte_t;
endpackage : lfosc_pkg

/* lf_edge_sync.sv */
/*
 * Three-stage synchroniser with agreement filter and edge pulses for an
 * input that arrives from outside the core clock domain.
 * Assumes core_clk is the only clock and reset_n is synchronous.
 */
`timescale 1ns/1ps
module lf_edge_sync (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import lfosc_pkg::*;

  logic meta_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;
  logic agree;

  // Stage one is read only by stage two
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q  <= 1'h0;
      sync2_q <= 1'h0;
      sync3_q <= 1'h0;
    end else begin
      meta_q  <= async_in;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // A change is accepted only once stages two and three agree
  assign agree = (sync2_q == sync3_q);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      level_q <= 1'h0;
    end else if (agree) begin
      level_q <= sync3_q;
    end
  end

  // One pulse per accepted change
  assign level = level_q;
  assign rise  = agree & sync3_q & ~level_q;
  assign fall  = agree & ~sync3_q & level_q;
endmodule : lf_edge_sync

/* low_freq_osc_control.sv */
/*
 * Control logic of the internal low-frequency oscillator: control register
 * on the special function register port, output divider, settling flag and
 * period capture for the two general timers.
 * Assumes the analog core is outside, its raw output is asynchronous to
 * core_clk, and the timers supply their running counts and capture modes.
 */
//
// What this block does
// - Divide oscillator output by 8, 4, 2 or 1 for codes 00..11.
// - Oscillator runs only while control bit 7 is set.
// - Bit 6 reads one once the oscillator has stabilised.
// - Ready clears only on reset or a changed divider selection.
// - Bits 5 to 2 trim frequency, all zeros fastest, all ones slowest.
// - Capture mode: first timer on falling edge, second on rising edge.
// - Each capture copies the timer's 16-bit count into its reload pair.
`timescale 1ns/1ps
`include "lfosc_params.svh"
module low_freq_osc_control #(
  parameter int SETTLE_EDGES = `LFOSC_SETTLE_EDGES,
  parameter logic [3:0] TRIM_RESET = `LFOSC_TRIM_RESET
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic [7:0]   sfr_addr,
  input  wire logic         sfr_wr,
  input  wire logic         sfr_rd,
  input  wire lfosc_pkg::sfr_byte_t sfr_wdata,
  output lfosc_pkg::sfr_byte_t      sfr_rdata,
  input  wire logic         lf_osc_raw,
  output logic              lf_osc_on,
  output logic [3:0]        lf_trim,
  output logic              lf_osc_div_clk,
  input  wire logic         timer2_lf_capture_mode,
  input  wire logic         timer3_lf_capture_mode,
  input  wire logic [7:0]   timer2_count_hi,
  input  wire logic [7:0]   timer2_count_lo,
  input  wire logic [7:0]   timer3_count_hi,
  input  wire logic [7:0]   timer3_count_lo,
  output logic [7:0]        timer2_reload_hi,
  output logic [7:0]        timer2_reload_lo,
  output logic [7:0]        timer3_reload_hi,
  output logic [7:0]        timer3_reload_lo,
  output logic              timer2_capture,
  output logic              timer3_capture
);
  import lfosc_pkg::*;

  // ============================================================
  // Control register
  logic          on_q;
  logic [3:0]    trim_q;
  logic [1:0]    divide_sel_q;
  logic          settled_q;
  sfr_byte_t     rdata_q;
  logic          ctrl_hit;
  logic          ctrl_wr;
  logic [1:0]    wr_div;
  logic          div_changed;
  sfr_byte_t     ctrl_image;

  assign ctrl_hit    = (sfr_addr == `LFOSC_CTRL_ADDR);
  assign ctrl_wr     = ctrl_hit & sfr_wr;
  assign wr_div      = sfr_wdata[`LFOSC_DIV_HI:`LFOSC_DIV_LO];
  assign div_changed = ctrl_wr & (wr_div != divide_sel_q);
  assign ctrl_image  = {on_q, settled_q, trim_q, divide_sel_q};

  // Writable fields; the settled bit ignores writes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      on_q         <= `LFOSC_ON_RESET;
      trim_q       <= TRIM_RESET;
      divide_sel_q <= `LFOSC_DIV_RESET;
    end else if (ctrl_wr) begin
      on_q         <= sfr_wdata[`LFOSC_ON_BIT];
      trim_q       <= sfr_wdata[`LFOSC_TRIM_HI:`LFOSC_TRIM_LO];
      divide_sel_q <= wr_div;
    end
  end

  // Read data follows a read strobe by one cycle, zero elsewhere
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= (ctrl_hit & sfr_rd) ? ctrl_image : 8'h00;
    end
  end

  // ============================================================
  // Oscillator edges into the core clock domain
  logic raw_level;
  logic raw_rise;
  logic raw_fall;
  logic run_rise;
  logic run_fall;

  lf_edge_sync raw_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (lf_osc_raw),
    .level    (raw_level),
    .rise     (raw_rise),
    .fall     (raw_fall)
  );

  // Edges count only while the oscillator is enabled
  assign run_rise = raw_rise & on_q;
  assign run_fall = raw_fall & on_q;

  // ============================================================
  // Output divider
  logic [2:0] div_cnt_q;
  logic       div_level;
  logic       div_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n || div_changed) begin
      div_cnt_q <= 3'h0;
    end else if (run_rise) begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // Counter bit n is the oscillator divided by 2 to the n+1
  assign div_level = (divide_sel_q == `LFOSC_DIV_BY8) ? div_cnt_q[2] :
                     (divide_sel_q == `LFOSC_DIV_BY4) ? div_cnt_q[1] :
                     (divide_sel_q == `LFOSC_DIV_BY2) ? div_cnt_q[0] :
                     (raw_level & on_q);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_q <= 1'h0;
    end else begin
      div_q <= div_level;
    end
  end

  // ============================================================
  // Settling sequencer
  settle_state_t state_q;
  settle_state_t state_d;
  logic [7:0]    settle_cnt_q;
  logic          settle_reached;

  assign settle_reached = (settle_cnt_q >= 8'(SETTLE_EDGES - 1)) & run_rise;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SETTLE_IDLE: begin
        if (on_q) state_d = SETTLE_WAIT;
      end
      SETTLE_WAIT: begin
        if (settle_reached) state_d = SETTLE_DONE;
      end
      SETTLE_DONE: begin
        state_d = SETTLE_DONE;
      end
      default: begin
        state_d = SETTLE_IDLE;
      end
    endcase
    if (div_changed) state_d = SETTLE_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= SETTLE_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || state_q != SETTLE_WAIT || div_changed) begin
      settle_cnt_q <= 8'h00;
    end else if (run_rise) begin
      settle_cnt_q <= settle_cnt_q + 8'h01;
    end
  end

  // Flag drops only on reset or a changed divider, never on disable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      settled_q <= 1'h0;
    end else begin
      settled_q <= (state_d == SETTLE_DONE);
    end
  end

  // ============================================================
  // Timer capture
  logic div_prev_q;
  logic cap2;
  logic cap3;
  logic cap2_q;
  logic cap3_q;
  logic [7:0] rl2_hi_q;
  logic [7:0] rl2_lo_q;
  logic [7:0] rl3_hi_q;
  logic [7:0] rl3_lo_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_prev_q <= 1'h0;
    end else begin
      div_prev_q <= div_q;
    end
  end

  // Falling edge for the first timer, rising for the second
  assign cap2 = timer2_lf_capture_mode & div_prev_q & ~div_q;
  assign cap3 = timer3_lf_capture_mode & ~div_prev_q & div_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cap2_q   <= 1'h0;
      cap3_q   <= 1'h0;
      rl2_hi_q <= 8'h00;
      rl2_lo_q <= 8'h00;
      rl3_hi_q <= 8'h00;
      rl3_lo_q <= 8'h00;
    end else begin
      cap2_q <= cap2;
      cap3_q <= cap3;
      if (cap2) begin
        rl2_hi_q <= timer2_count_hi;
        rl2_lo_q <= timer2_count_lo;
      end
      if (cap3) begin
        rl3_hi_q <= timer3_count_hi;
        rl3_lo_q <= timer3_count_lo;
      end
    end
  end

  // ============================================================
  // Outputs
  assign sfr_rdata        = rdata_q;
  assign lf_osc_on        = on_q;
  assign lf_trim          = trim_q;
  assign lf_osc_div_clk   = div_q;
  assign timer2_reload_hi = rl2_hi_q;
  assign timer2_reload_lo = rl2_lo_q;
  assign timer3_reload_hi = rl3_hi_q;
  assign timer3_reload_lo = rl3_lo_q;
  assign timer2_capture   = cap2_q;
  assign timer3_capture   = cap3_q;
endmodule : low_freq_osc_control

/* lfosc_chk_assertions.sv */
/* Checker for the low-frequency oscillator control block ports.
   Assumes lfosc_params.svh on the include path and one clock. */
`timescale 1ns/1ps
`include "lfosc_params.svh"
module lfosc_chk #(
  parameter int SETTLE_EDGES = `LFOSC_SETTLE_EDGES
) (
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  input wire logic [7:0]           sfr_addr,
  input wire logic                 sfr_wr,
  input wire logic                 sfr_rd,
  input wire lfosc_pkg::sfr_byte_t sfr_wdata,
  input wire lfosc_pkg::sfr_byte_t sfr_rdata,
  input wire logic                 lf_osc_on,
  input wire logic [3:0]           lf_trim,
  input wire logic                 lf_osc_div_clk,
  input wire logic                 timer2_lf_capture_mode,
  input wire logic                 timer3_lf_capture_mode,
  input wire logic [7:0]           timer2_count_hi,
  input wire logic [7:0]           timer2_count_lo,
  input wire logic [7:0]           timer2_reload_hi,
  input wire logic [7:0]           timer2_reload_lo,
  input wire logic [7:0]           timer3_count_hi,
  input wire logic [7:0]           timer3_count_lo,
  input wire logic [7:0]           timer3_reload_hi,
  input wire logic [7:0]           timer3_reload_lo,
  input wire logic                 timer2_capture,
  input wire logic                 timer3_capture
);
  import lfosc_pkg::*;
  // ====
  // Decode and capture sequences
  wire ctrl_wr = sfr_wr && (sfr_addr == `LFOSC_CTRL_ADDR);
  wire ctrl_rd = sfr_rd && (sfr_addr == `LFOSC_CTRL_ADDR);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence div_fall;
    $fell(lf_osc_div_clk) && timer2_lf_capture_mode;
  endsequence
  sequence div_rise;
    $rose(lf_osc_div_clk) && timer3_lf_capture_mode;
  endsequence
  // ====
  // Assertions
  on_write_a: assert property (
    ctrl_wr |=> lf_osc_on == $past(sfr_wdata[`LFOSC_ON_BIT]))
    else $error("enable");
  trim_write_a: assert property (
    ctrl_wr |=> lf_trim == $past(sfr_wdata[`LFOSC_TRIM_HI:`LFOSC_TRIM_LO]))
    else $error("trim");
  ctrl_hold_a: assert property (
    !ctrl_wr |=> $stable(lf_osc_on) && $stable(lf_trim)) else $error("hold");
  rd_image_a: assert property (
    ctrl_rd |=> sfr_rdata[7] == $past(lf_osc_on)
      && sfr_rdata[5:2] == $past(lf_trim)) else $error("read image");
  cap2_edge_a: assert property (
    div_fall |=> timer2_capture) else $error("timer2 capture");
  cap3_edge_a: assert property (
    div_rise |=> timer3_capture) else $error("timer3 capture");
  cap_pulse_a: assert property (
    timer2_capture |=> !timer2_capture) else $error("pulse width");
  cap2_load_a: assert property (
    timer2_capture |-> {timer2_reload_hi, timer2_reload_lo}
      == $past({timer2_count_hi, timer2_count_lo})) else $error("reload");
  cap3_load_a: assert property (
    timer3_capture |-> {timer3_reload_hi, timer3_reload_lo}
      == $past({timer3_count_hi, timer3_count_lo})) else $error("reload3");
  // Disabled two cycles and no control register write the cycle before: the output must stand still
  off_quiet_a: assert property (
    !lf_osc_on && !$past(lf_osc_on) && !$past(ctrl_wr)
      |=> $stable(lf_osc_div_clk)) else $error("divider ran while off");
  idle_read_a: assert property (
    !ctrl_rd |=> sfr_rdata == 8'h00) else $error("read data not idle");
endmodule : lfosc_chk

bind low_freq_osc_control lfosc_chk #(.SETTLE_EDGES(SETTLE_EDGES)) i_chk (.*);

/* tb.sv */
/* Self-checking bench for the low-frequency oscillator control block.
   Assumes the package and lfosc_params.svh are compiled first. */
`timescale 1ns/1ps
module tb;
  import lfosc_pkg::*;
  logic       core_clk = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0;
  logic       lf_osc_raw = 0, lf_osc_on, lf_osc_div_clk;
  logic [7:0] sfr_addr = 0;
  sfr_byte_t  sfr_wdata = 0, sfr_rdata, d;
  logic [3:0] lf_trim, t;
  logic       timer2_lf_capture_mode = 0, timer3_lf_capture_mode = 0;
  logic [7:0] timer2_count_hi = 0, timer2_count_lo = 0;
  logic [7:0] timer3_count_hi = 0, timer3_count_lo = 0;
  logic [7:0] timer2_reload_hi, timer2_reload_lo;
  logic [7:0] timer3_reload_hi, timer3_reload_lo;
  logic       timer2_capture, timer3_capture, osc_run = 0, div_p = 0;
  logic [31:0] seed = 32'h3293;
  int failures = 0, n_compared = 0, hp = 10, cnt = 0, n_rise = 0, n_cap = 0;
  int          e = 0;
  logic [15:0] r1;
  logic        count_run = 0;

  low_freq_osc_control #(.SETTLE_EDGES(2)) i_dut (.*);

  // ====
  // Clock, raw oscillator and output monitor
  always #2 core_clk = ~core_clk;
  always @(negedge core_clk) if (osc_run) begin
    cnt = cnt + 1;
    if (cnt >= hp) begin
      cnt = 0;
      lf_osc_raw = ~lf_osc_raw;
    end
  end
  // Timer 2 count runs on request so that captures span real time
  always @(negedge core_clk) if (count_run) begin
    {timer2_count_hi, timer2_count_lo} =
      {timer2_count_hi, timer2_count_lo} + 16'h1;
  end
  // Outputs are looked at once they have settled after the edge
  always @(posedge core_clk) begin
    #1;
    if (lf_osc_div_clk === 1'b1 && div_p === 1'b0) n_rise++;
    if (timer2_capture === 1'b1) n_cap++;
    div_p = lf_osc_div_clk;
  end

  // ====
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Divided rising edges in a window, for divider code and half period
  function automatic int exp_rises(input int code, input int half,
                                   input int cycles);
    return cycles / (2 * half) / (8 >> code);
  endfunction : exp_rises
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic wr(input sfr_byte_t v);
    @(negedge core_clk);
    sfr_addr = 8'h86;
    sfr_wdata = v;
    sfr_wr = 1;
    @(negedge core_clk);
    sfr_wr = 0;
  endtask : wr
  task automatic rd(input sfr_byte_t a);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge core_clk);
    sfr_rd = 0;
    d = sfr_rdata;
  endtask : rd
  // Wait for one capture pulse, then check level and reload pair
  task automatic cap(input logic three);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge core_clk);
      #1;
      if ((three ? timer3_capture : timer2_capture) === 1'b1) break;
    end
    if (i == 300) begin
      chk(16'h0, 16'h1);
      stop_test();
    end else begin
      chk(lf_osc_div_clk, three);
      if (three) chk({timer3_reload_hi, timer3_reload_lo},
                     {timer3_count_hi, timer3_count_lo});
      else chk({timer2_reload_hi, timer2_reload_lo},
               {timer2_count_hi, timer2_count_lo});
    end
  endtask : cap

  // ====
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1;
    rd(8'h86); chk(d, 8'h00);
    rd(8'h87); chk(d, 8'h00);
    seed = lfsr(seed);
    t = seed[3:0];
    wr({2'h0, t, 2'h3});
    wr({2'h3, t, 2'h3});
    rd(8'h86); chk(d, {2'h2, t, 2'h3});
    chk({lf_osc_on, lf_trim}, {1'b1, t});
    osc_run = 1;
    repeat (80) @(negedge core_clk);
    rd(8'h86); chk(d[6], 1'b1);
    seed = lfsr(seed);
    {timer2_count_hi, timer2_count_lo, timer3_count_hi} = seed[23:0];
    timer3_count_lo = seed[31:24];
    timer2_lf_capture_mode = 1;
    cap(0);
    // Two successive captures of a running count span one period
    count_run = 1;
    cap(0);
    r1 = {timer2_reload_hi, timer2_reload_lo};
    cap(0);
    chk({timer2_reload_hi, timer2_reload_lo} - r1, 16'(2 * hp));
    count_run = 0;
    @(negedge core_clk) timer2_lf_capture_mode = 0;
    timer3_lf_capture_mode = 1;
    cap(1);
    @(negedge core_clk) timer3_lf_capture_mode = 0;
    hp = 6;
    for (int c = 0; c < 4; c++) begin
      wr({2'h2, t, c[1:0]});
      n_rise = 0;
      repeat (768) @(negedge core_clk);
      e = exp_rises(c, hp, 768);
      chk(n_rise >= e - 1 && n_rise <= e + 1, 1'b1);
    end
    rd(8'h86); chk(d[6], 1'b1);
    // Reset in mid-run drops ready and restores every field
    @(negedge core_clk) reset_n = 0;
    repeat (4) @(negedge core_clk);
    reset_n = 1;
    rd(8'h86); chk(d, 8'h00);
    chk({lf_osc_on, lf_trim}, 16'h0);
    wr({2'h2, t, 2'h3});
    repeat (80) @(negedge core_clk);
    rd(8'h86); chk(d[6], 1'b1);
    osc_run = 0;
    wr({2'h2, t, 2'h3});
    rd(8'h86); chk(d[6], 1'b1);
    wr({2'h2, t, 2'h1});
    rd(8'h86); chk(d[6], 1'b0);
    wr({2'h0, t, 2'h3});
    osc_run = 1;
    timer2_lf_capture_mode = 1;
    repeat (10) @(negedge core_clk);
    n_rise = 0;
    n_cap = 0;
    repeat (200) @(negedge core_clk);
    chk(n_rise + n_cap, 16'h0);
    stop_test();
  end
endmodule : tb
